//--- rtl/dpdcs_ref_div.v
// refresh request divider: counts sampled refresh clock rising edges
`timescale 1ns/1ps
`default_nettype none
`include "dpdcs_regs.vh"
module dpdcs_ref_div (
  input  wire       i_clk,
  input  wire       i_reset,
  input  wire       i_refresh_clk,
  input  wire       i_busy,
  output reg        o_tick
);
  reg       rclk_d_reg;
  reg [5:0] cnt_reg;
  wire      rise = i_refresh_clk & ~rclk_d_reg;

  // one tick every 64 refresh clock rising edges, suppressed while refreshing
  always @(posedge i_clk) begin
    if (i_reset) begin
      rclk_d_reg <= 1'b0;
      cnt_reg    <= 6'h00;
      o_tick     <= 1'b0;
    end else begin
      rclk_d_reg <= i_refresh_clk;
      o_tick     <= 1'b0;
      if (rise) begin
        cnt_reg <= cnt_reg + 6'h01;
        if (cnt_reg == 6'h3f) begin
          o_tick <= ~i_busy;
        end
      end
    end
  end
endmodule // dpdcs_ref_div
`default_nettype wire

//--- rtl/dpdcs_regs.vh
// timing constants and field layout for the dual-port dram cycle sequencer
`ifndef DPDCS_REGS_VH
`define DPDCS_REGS_VH
`define DPDCS_CLK_PERIOD_NS  40
`define DPDCS_REF_DIV        64
`define DPDCS_RAS_REF_HALF   8
`define DPDCS_PRE_REF_HALF   6
`define DPDCS_RAS_ACC_HALF   6
`define DPDCS_ADDR_W         18
`define DPDCS_MA_W           9
`define DPDCS_ROW_LSB        0
`define DPDCS_COL_LSB        9
`define DPDCS_REFROW_RESET   9'h000
`endif

//--- rtl/dpdcs_top.v
// cycle sequencer of a clocked dual-port dram controller
// ----------------------------------------------------------------
// ----------------------------------------------------------------
// one step of the phase counter is one clock of the 25 MHz clock,
// so labelled edges B..E fall on successive phase values 1..4, and F on phase 8.
`timescale 1ns/1ps
`default_nettype none
`include "dpdcs_regs.vh"
module dpdcs_top (
  input  wire        I_CLK,
  input  wire        I_RESET,
  input  wire        I_REFRESH_CLK,
  input  wire        I_REQUEST_1_N,
  input  wire        I_REQUEST_2_N,
  input  wire [17:0] I_ADDR,
  output reg         O_SELECT_1_N,
  output reg         O_SELECT_2_N,
  output reg         O_GRANT,
  output reg         O_ROW_STROBE_N,
  output reg         O_WRITE_GATE,
  output reg         O_COLUMN_STROBE_ENABLE_N,
  output reg         O_TRANSFER_ACK,
  output reg  [8:0]  O_MEM_ADDR,
  output wire [1:0]  O_CYCLE
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REF  = 2'b01;
  localparam [1:0] ST_ACC1 = 2'b10;
  localparam [1:0] ST_ACC2 = 2'b11;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [3:0]  phase_reg;
  reg  [17:0] addr_reg;
  reg  [8:0]  refrow_reg;
  reg         refpend_reg;
  wire        ref_tick;
  wire        in_ref = (state_reg == ST_REF);
  wire        request_1_n   = ~I_REQUEST_1_N;
  wire        request_2_n   = ~I_REQUEST_2_N;

  dpdcs_ref_div u_div (
    .i_clk         (I_CLK),
    .i_reset       (I_RESET),
    .i_refresh_clk (I_REFRESH_CLK),
    .i_busy        (in_ref),
    .o_tick        (ref_tick)
  );

  assign O_CYCLE = state_reg;

  // ----------------------------------------------------------------
  // next cycle choice
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (refpend_reg | ref_tick) begin
          state_next = ST_REF;
        end else if (request_1_n) begin
          state_next = ST_ACC1;
        end else if (request_2_n) begin
          state_next = ST_ACC2;
        end
      end
      ST_REF: begin
        if (phase_reg == 4'd14) begin
          state_next = ST_IDLE;
        end
      end
      ST_ACC1: begin
        if (phase_reg == 4'd8 && !request_1_n) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        if (phase_reg == 4'd8 && !request_2_n) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // access phases: 1=B grant/row, 2=C ras, 3=D col/wg, 4=E column_strobe_enable_n,
  // 8=F ras off/ack (ras low 6 clocks after C), hold until G.
  // refresh: 1 row addr, 2..9 ras low (8 clocks), 10..14 high (5 clocks).
  always @(posedge I_CLK) begin
    if (I_RESET) begin
      state_reg                <= ST_IDLE;
      phase_reg                <= 4'h0;
      addr_reg                 <= 18'h00000;
      refrow_reg               <= `DPDCS_REFROW_RESET;
      refpend_reg              <= 1'b0;
      O_SELECT_1_N             <= 1'b1;
      O_SELECT_2_N             <= 1'b1;
      O_GRANT                  <= 1'b0;
      O_ROW_STROBE_N           <= 1'b1;
      O_WRITE_GATE             <= 1'b0;
      O_COLUMN_STROBE_ENABLE_N <= 1'b1;
      O_TRANSFER_ACK           <= 1'b0;
      O_MEM_ADDR               <= 9'h000;
    end else begin
      state_reg <= state_next;
      // an idle tick starts the refresh at once, so only a tick that meets
      // an access is kept; set and clear can then never meet in one cycle
      if (ref_tick && (state_reg == ST_ACC1 || state_reg == ST_ACC2)) begin
        refpend_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && state_next == ST_REF) begin
        refpend_reg <= 1'b0;
      end
      if (state_next != state_reg) begin
        phase_reg <= 4'h1;
      end else if (state_reg != ST_IDLE && phase_reg != 4'h8 || in_ref) begin
        phase_reg <= phase_reg + 4'h1;
      end
      O_SELECT_1_N <= ~(state_next == ST_ACC1);
      O_SELECT_2_N <= ~(state_next == ST_ACC2);
      case (state_next)
        ST_IDLE: begin
          O_GRANT                  <= 1'b0;
          O_ROW_STROBE_N           <= 1'b1;
          O_WRITE_GATE             <= 1'b0;
          O_COLUMN_STROBE_ENABLE_N <= 1'b1;
          O_TRANSFER_ACK           <= 1'b0;
        end
        ST_REF: begin
          // the refresh never touches the column strobe
          if (state_reg == ST_IDLE) begin
            O_MEM_ADDR <= refrow_reg;
          end else if (phase_reg == 4'd1) begin
            O_ROW_STROBE_N <= 1'b0;
          end else if (phase_reg == 4'd9) begin
            O_ROW_STROBE_N <= 1'b1;
            refrow_reg     <= refrow_reg + 9'h001;
          end
        end
        default: begin
          if (state_reg == ST_IDLE) begin
            O_GRANT    <= 1'b1;
            addr_reg   <= I_ADDR;
            O_MEM_ADDR <= I_ADDR[8:0];
          end else begin
            case (phase_reg)
              4'd1: O_ROW_STROBE_N <= 1'b0;
              4'd2: begin
                O_MEM_ADDR   <= addr_reg[17:9];
                O_WRITE_GATE <= 1'b1;
              end
              4'd3: O_COLUMN_STROBE_ENABLE_N <= 1'b0;
              4'd7: begin
                O_ROW_STROBE_N <= 1'b1;
                O_TRANSFER_ACK <= 1'b1;
              end
              default: ;
            endcase
          end
        end
      endcase
    end
  end
endmodule // dpdcs_top
`default_nettype wire

//--- verification/dpdcs_assertions.sv
// port-level checks of the dram cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dpdcs_assertions (
  input wire logic       I_CLK,
  input wire logic       I_RESET,
  input wire logic       I_REQUEST_1_N,
  input wire logic       I_REQUEST_2_N,
  input wire logic       O_SELECT_1_N,
  input wire logic       O_SELECT_2_N,
  input wire logic       O_GRANT,
  input wire logic       O_ROW_STROBE_N,
  input wire logic       O_WRITE_GATE,
  input wire logic       O_COLUMN_STROBE_ENABLE_N,
  input wire logic       O_TRANSFER_ACK,
  input wire logic [1:0] O_CYCLE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  wire own_req_n = O_CYCLE[0] ? I_REQUEST_2_N : I_REQUEST_1_N;
  sequence ref_on; !O_ROW_STROBE_N [*8]; endsequence
  sequence ref_off; O_ROW_STROBE_N [*5] ##1 (O_ROW_STROBE_N && O_CYCLE == 2'd0); endsequence
  row_strobe_a: assert property ($rose(O_GRANT) |=> $fell(O_ROW_STROBE_N))
    else $error("row strobe late");
  write_gate_a: assert property ($rose(O_GRANT) |-> ##2 $rose(O_WRITE_GATE))
    else $error("write gate late");
  col_enable_a: assert property ($rose(O_WRITE_GATE) |=> $fell(O_COLUMN_STROBE_ENABLE_N))
    else $error("column enable late");
  ack_edge_a: assert property ($fell(O_COLUMN_STROBE_ENABLE_N) |-> ##4
    ($rose(O_TRANSFER_ACK) && $rose(O_ROW_STROBE_N))) else $error("ack edge wrong");
  release_a: assert property (O_TRANSFER_ACK && own_req_n |-> ##[1:2] !(O_GRANT ||
    O_WRITE_GATE || O_TRANSFER_ACK || !O_COLUMN_STROBE_ENABLE_N)) else $error("no release");
  hold_state_a: assert property (O_TRANSFER_ACK && !own_req_n && !$past(own_req_n)
    |=> O_TRANSFER_ACK) else $error("ack dropped early");
  one_owner_a: assert property (O_GRANT |-> O_CYCLE[1] && O_SELECT_1_N != O_SELECT_2_N
    && O_SELECT_1_N == O_CYCLE[0]) else $error("owner mismatch");
  start_idle_a: assert property ($rose(O_GRANT) |-> $past(O_CYCLE) == 2'd0)
    else $error("access overlaps");
  ras_only_a: assert property (O_CYCLE == 2'd1 |-> O_COLUMN_STROBE_ENABLE_N && !O_GRANT)
    else $error("column strobe in refresh");
  refresh_shape_a: assert property ($fell(O_ROW_STROBE_N) && O_CYCLE == 2'd1
    |-> ref_on ##1 ref_off) else $error("refresh shape");
endmodule // dpdcs_assertions
bind dpdcs_top dpdcs_assertions u_chk (.*);
`default_nettype wire

//--- verification/dpdcs_cpu.sv
// processor model: requests the bank, withdraws after a dwell
`timescale 1ns/1ps
`default_nettype none
module dpdcs_cpu (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [8:0] i_hold,
  input  wire logic       i_sel_n,
  input  wire logic       i_ack,
  output logic            o_req_n
);
  logic [8:0] cnt_reg;
  initial o_req_n = 1'b1;
  always @(posedge i_clk) begin
    if (o_req_n) begin
      cnt_reg <= 9'h000;
      if (i_go && !i_ack) o_req_n <= 1'b0;
    end else if (i_ack && !i_sel_n) begin
      cnt_reg <= cnt_reg + 9'h001;
      // a long dwell models a slow bus cycle
      if (cnt_reg == i_hold) o_req_n <= 1'b1;
    end
  end
endmodule // dpdcs_cpu
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the dram cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin samples_checked++; if ((g)!==(e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic        clk = 0, rst = 1, rclk = 0, go1 = 0, go2 = 0;
  logic [8:0]  h1 = 0, rr;
  logic [17:0] a = 0;
  wire         r1, r2, s1, s2, gnt, ras, wg, cas, ack;
  wire  [8:0]  ma;
  wire  [1:0]  cyc;
  int          err_total = 0, samples_checked = 0;
  time         t0;
  initial forever #20 clk = ~clk;
  always @(posedge clk) rclk <= ~rclk;
  dpdcs_top dut (.I_CLK(clk), .I_RESET(rst), .I_REFRESH_CLK(rclk), .I_REQUEST_1_N(r1),
    .I_REQUEST_2_N(r2), .I_ADDR(a), .O_SELECT_1_N(s1), .O_SELECT_2_N(s2), .O_GRANT(gnt),
    .O_ROW_STROBE_N(ras), .O_WRITE_GATE(wg), .O_COLUMN_STROBE_ENABLE_N(cas),
    .O_TRANSFER_ACK(ack), .O_MEM_ADDR(ma), .O_CYCLE(cyc));
  dpdcs_cpu p1 (.i_clk(clk), .i_go(go1), .i_hold(h1), .i_sel_n(s1), .i_ack(ack), .o_req_n(r1));
  dpdcs_cpu p2 (.i_clk(clk), .i_go(go2), .i_hold(9'h002), .i_sel_n(s2), .i_ack(ack),
    .o_req_n(r2));
  // ----
  // scenarios
  // ----
  task automatic wc(input logic [1:0] s, input bit eq);
    int k = 0;
    while ((cyc === s) != eq && k < 600) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK("cycle", eq, cyc === s)
  endtask
  task automatic t_single;
    @(posedge clk);
    a <= 18'h2a5b3;
    h1 <= 9'h002;
    go1 <= 1;
    wc(2'd2, 1);
    `CHK("row", 9'h1b3, ma)
    @(posedge clk);
    go1 <= 0;
    a <= 18'h3ffff;
    @(posedge clk);
    #1;
    `CHK("col", 9'h152, ma)
    wc(2'd0, 1);
    `CHK("idle", 4'b0010, {gnt, wg, cas, ack})
  endtask
  task automatic t_contend;
    @(posedge clk);
    h1 <= 9'd200;
    go1 <= 1;
    go2 <= 1;
    wc(2'd2, 1);
    `CHK("select_2_n", 1'b1, s2)
    @(posedge clk);
    go1 <= 0;
    go2 <= 0;
    wc(2'd0, 1);
    wc(2'd0, 0);
    `CHK("next", 2'd1, cyc)
    wc(2'd3, 1);
    `CHK("select_1_n", 1'b1, s1)
    wc(2'd0, 1);
  endtask
  task automatic t_refresh;
    wc(2'd1, 1);
    wc(2'd0, 1);
    wc(2'd1, 1);
    rr = ma;
    t0 = $time;
    wc(2'd0, 1);
    wc(2'd1, 1);
    `CHK("period", 64 * 2, ($time - t0) / 40)
    `CHK("refrow", rr + 9'h001, ma)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(40 * 3000);
    err_total++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_single;
    t_contend;
    t_refresh;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
